// ---- core/ddr_quad_read.sv ----
// Device-side four-line double-data-rate read engine with continuous mode
module ddr_quad_read
  import ddr_quad_pkg::*;
#(
  parameter int MEM_ADDR_W = MEM_ADDR_W_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic sckPin,
  input wire logic csnPin,
  input wire logic [3:0] ioIn,
  output logic [3:0] ioOut,
  output logic [3:0] ioOe,
  input wire logic quadEnable,
  input wire logic addrWidth,
  input wire logic fourLineInstr,
  input wire logic [3:0] readLatency,
  input wire logic dlpEnable,
  input wire logic [7:0] dlpPattern,
  input wire logic loadEn,
  input wire logic [MEM_ADDR_W-1:0] loadAddr,
  input wire logic [7:0] loadData,
  output logic contModeOut,
  output logic busyOut
);

  // Upper and lower mode nibbles are bitwise complements
  function automatic logic isComplement(input logic [3:0] hi, input logic [3:0] lo);
    isComplement = (hi == ~lo);
  endfunction : isComplement

  logic rstS1_r;
  logic rstSync;
  logic [2:0] sckSync_r;
  logic [2:0] csnSync_r;
  logic [3:0] ioS1_r;
  logic [3:0] ioS2_r;
  logic [3:0] ioS3_r;
  logic sckF_r;
  logic csnF_r;
  logic [3:0] ioF_r;
  logic sckPrev_r;
  logic csnPrev_r;
  logic sckRise;
  logic sckFall;
  logic csnRise;
  logic csnFall;
  logic edgeHit;
  state_t state_r;
  logic [5:0] edgeCnt_r;
  logic [7:0] cmd_r;
  logic [31:0] addr_r;
  logic [3:0] modeHi_r;
  logic fourByte_r;
  logic modeDone_r;
  logic modeOk_r;
  logic rstSeen_r;
  logic contMode_r;
  logic [5:0] latency2;
  logic [5:0] addrLen;
  logic [7:0] cmdShift;
  logic cmdLast;
  logic addrTake;
  logic fetching_r;
  logic rdPend_r;
  logic [MEM_ADDR_W-1:0] rdAddr_r;
  logic [7:0] memData;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoPop;
  logic [7:0] fifoHead;
  logic memRd;
  logic [6:0] preSum;
  logic [6:0] preIdx;
  logic isPre;
  logic preBit;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rstS1_r <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstS1_r <= 1'b1;
      rstSync <= rstS1_r;
    end
  end

  // Pin sampling: a change counts only once stages two and three agree
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      sckSync_r <= 3'h0;
      csnSync_r <= 3'h7;
      ioS1_r <= 4'h0;
      ioS2_r <= 4'h0;
      ioS3_r <= 4'h0;
      sckF_r <= 1'b0;
      csnF_r <= 1'b1;
      ioF_r <= 4'h0;
      sckPrev_r <= 1'b0;
      csnPrev_r <= 1'b1;
    end
    else if (ce)
    begin
      sckSync_r <= {sckSync_r[1:0], sckPin};
      csnSync_r <= {csnSync_r[1:0], csnPin};
      ioS1_r <= ioIn;
      ioS2_r <= ioS1_r;
      ioS3_r <= ioS2_r;
      if (sckSync_r[1] == sckSync_r[2])
      begin
        sckF_r <= sckSync_r[1];
      end
      if (csnSync_r[1] == csnSync_r[2])
      begin
        csnF_r <= csnSync_r[1];
      end
      ioF_r <= (ioF_r & (ioS2_r ^ ioS3_r)) | (ioS2_r & ~(ioS2_r ^ ioS3_r));
      sckPrev_r <= sckF_r;
      csnPrev_r <= csnF_r;
    end
  end

  // Edge finding on the filtered pins; both clock edges count in a frame
  assign sckRise = sckF_r && !sckPrev_r;
  assign sckFall = !sckF_r && sckPrev_r;
  assign csnRise = csnF_r && !csnPrev_r;
  assign csnFall = !csnF_r && csnPrev_r;
  assign edgeHit = (sckRise || sckFall) && !csnF_r;

  // Phase lengths
  assign latency2 = {1'b0, readLatency, 1'b0};
  assign addrLen = fourByte_r ? ADDR4_EDGES : ADDR3_EDGES;
  assign cmdShift = fourLineInstr ? {cmd_r[3:0], ioF_r} : {cmd_r[6:0], ioF_r[0]};
  assign cmdLast = (edgeCnt_r + 6'h01) == (fourLineInstr ? QPI_CMD_EDGES : SPI_CMD_EDGES);
  // The first address nibble waits for a rising edge
  assign addrTake = !(sckFall && edgeCnt_r == 6'h00);

  ////////////////////////////////////////////////////////////////////////////////
  // Frame sequencer: instruction, address, mode, dummy, data
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      state_r <= ST_IDLE;
      edgeCnt_r <= 6'h00;
      cmd_r <= 8'h00;
      addr_r <= 32'h0;
      modeHi_r <= 4'h0;
      fourByte_r <= 1'b0;
      modeDone_r <= 1'b0;
      modeOk_r <= 1'b0;
      rstSeen_r <= 1'b0;
    end
    else if (ce)
    begin
      if (csnF_r)
      begin
        state_r <= ST_IDLE;
        edgeCnt_r <= 6'h00;
      end
      else if (csnFall)
      begin
        // Continuous mode skips the instruction byte
        state_r <= contMode_r ? ST_ADDR : ST_CMD;
        edgeCnt_r <= 6'h00;
        addr_r <= 32'h0;
        modeDone_r <= 1'b0;
        rstSeen_r <= 1'b0;
      end
      else if (edgeHit)
      begin
        case (state_r)
          ST_CMD:
          begin
            if (sckRise)
            begin
              cmd_r <= cmdShift;
              edgeCnt_r <= cmdLast ? 6'h00 : edgeCnt_r + 6'h01;
              if (cmdLast)
              begin
                if (!quadEnable)
                begin
                  state_r <= ST_IGNORE;
                end
                else if (cmdShift == CMD_READ_DDR)
                begin
                  fourByte_r <= addrWidth;
                  state_r <= ST_ADDR;
                end
                else if (cmdShift == CMD_READ_DDR4)
                begin
                  fourByte_r <= 1'b1;
                  state_r <= ST_ADDR;
                end
                else
                begin
                  state_r <= ST_IGNORE;
                end
              end
            end
          end
          ST_ADDR:
          begin
            if (addrTake)
            begin
              addr_r <= {addr_r[27:0], ioF_r};
              // All-ones first byte is the mode reset while continuous
              if (edgeCnt_r == 6'h01 && {addr_r[3:0], ioF_r} == CMD_MODE_RESET)
              begin
                rstSeen_r <= 1'b1;
              end
              if (edgeCnt_r + 6'h01 == addrLen)
              begin
                state_r <= ST_MODE;
                edgeCnt_r <= 6'h00;
              end
              else
              begin
                edgeCnt_r <= edgeCnt_r + 6'h01;
              end
            end
          end
          ST_MODE:
          begin
            modeHi_r <= ioF_r;
            if (edgeCnt_r + 6'h01 == MODE_EDGES)
            begin
              modeDone_r <= 1'b1;
              modeOk_r <= isComplement(modeHi_r, ioF_r);
              state_r <= (latency2 == 6'h00) ? ST_DATA : ST_DUMMY;
              edgeCnt_r <= 6'h00;
            end
            else
            begin
              edgeCnt_r <= edgeCnt_r + 6'h01;
            end
          end
          ST_DUMMY:
          begin
            // Line values are ignored here
            if (edgeCnt_r + 6'h01 == latency2)
            begin
              state_r <= ST_DATA;
              edgeCnt_r <= 6'h00;
            end
            else
            begin
              edgeCnt_r <= edgeCnt_r + 6'h01;
            end
          end
          ST_DATA:
          begin
            // Only the nibble parity matters once data flow
            edgeCnt_r <= {5'h00, ~edgeCnt_r[0]};
          end
          ST_IDLE, ST_IGNORE:
          begin
            edgeCnt_r <= edgeCnt_r;
          end
          default:
          begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Continuous mode changes only at the end of the frame that decided it
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      contMode_r <= 1'b0;
    end
    else if (ce && csnRise)
    begin
      if (modeDone_r)
      begin
        contMode_r <= modeOk_r;
      end
      else if (rstSeen_r || cmd_r == CMD_MODE_RESET)
      begin
        contMode_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Prefetch: bytes are read ahead into the FIFO, so the internal address
  // runs ahead of the byte on the lines; ready from the FIFO stalls it
  assign memRd = fetching_r && !rdPend_r && fifoInReady && !csnF_r;

  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      fetching_r <= 1'b0;
      rdPend_r <= 1'b0;
      rdAddr_r <= '0;
    end
    else if (ce)
    begin
      if (csnF_r)
      begin
        fetching_r <= 1'b0;
        rdPend_r <= 1'b0;
      end
      else if (state_r == ST_MODE && edgeHit && edgeCnt_r + 6'h01 == MODE_EDGES)
      begin
        // Any byte location may start; high address bits fall outside the array
        rdAddr_r <= addr_r[MEM_ADDR_W-1:0];
        fetching_r <= 1'b1;
      end
      else if (memRd)
      begin
        rdPend_r <= 1'b1;
      end
      else if (rdPend_r)
      begin
        rdPend_r <= 1'b0;
        rdAddr_r <= rdAddr_r + 1'b1;
      end
    end
  end

  byte_array #(
    .AW(MEM_ADDR_W),
    .DW(BYTE_W)
  ) u_array (
    .clk(clk),
    .ce(ce),
    .wrEn(loadEn),
    .wrAddr(loadAddr),
    .wrData(loadData),
    .rdEn(memRd),
    .rdAddr(rdAddr_r),
    .rdData(memData)
  );

  // One byte leaves the FIFO after its low nibble has been shown
  assign fifoPop = (state_r == ST_DATA) && edgeHit && edgeCnt_r[0];

  byte_fifo #(
    .W(BYTE_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstSync),
    .ce(ce),
    .flush(csnF_r),
    .inValid(rdPend_r),
    .inReady(fifoInReady),
    .inData(memData),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoHead)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Preamble slot: the last eight dummy edges (every dummy edge when there are fewer), pattern sent MSB first
  assign preSum = {1'b0, edgeCnt_r} + PREAMBLE_EDGES;
  assign isPre = preSum >= {1'b0, latency2};
  assign preIdx = preSum - {1'b0, latency2};
  assign preBit = dlpPattern[3'h7 - preIdx[2:0]];

  // Line drivers; registered, so they follow the sequencer by one clock
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      ioOut <= 4'h0;
      ioOe <= 4'h0;
    end
    else if (ce)
    begin
      if (!csnF_r && state_r == ST_DATA)
      begin
        ioOe <= 4'hF;
        ioOut <= edgeCnt_r[0] ? fifoHead[3:0] : fifoHead[7:4];
      end
      else if (!csnF_r && state_r == ST_DUMMY && dlpEnable && isPre)
      begin
        ioOe <= 4'hF;
        ioOut <= {4{preBit}};
      end
      else
      begin
        // Lines float otherwise, dummy cycles included
        ioOe <= 4'h0;
        ioOut <= 4'h0;
      end
    end
  end

  // Status outputs
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      contModeOut <= 1'b0;
      busyOut <= 1'b0;
    end
    else if (ce)
    begin
      contModeOut <= contMode_r;
      busyOut <= (state_r != ST_IDLE) || fifoOutValid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_quad_gate: assert property (@(posedge clk) disable iff (!rstSync)
    (ce && state_r == ST_CMD && edgeHit && sckRise && cmdLast && !quadEnable && !csnFall)
    |=> state_r == ST_IGNORE)
    else $error("read taken without quad enable");

  a_addr_length: assert property (@(posedge clk) disable iff (!rstSync)
    (state_r == ST_MODE && $past(state_r) == ST_ADDR)
    |-> $past(edgeCnt_r) + 6'h01 == addrLen)
    else $error("wrong address length");

  a_addr_nibble: assert property (@(posedge clk) disable iff (!rstSync)
    (ce && state_r == ST_ADDR && edgeHit && addrTake && !csnFall)
    |=> addr_r[3:0] == $past(ioF_r))
    else $error("address nibble not captured");

  a_cont_enter: assert property (@(posedge clk) disable iff (!rstSync)
    (ce && csnRise && modeDone_r && modeOk_r)
    |=> contMode_r ##1 (!ce || contModeOut))
    else $error("continuous mode not entered");

  a_cont_exit: assert property (@(posedge clk) disable iff (!rstSync)
    (ce && csnRise && modeDone_r && !modeOk_r) |=> !contMode_r)
    else $error("continuous mode not left");

  a_addr_step: assert property (@(posedge clk) disable iff (!rstSync)
    (ce && rdPend_r && !csnF_r) |=> rdAddr_r == $past(rdAddr_r) + 1'b1)
    else $error("address did not advance");

  a_dummy_quiet: assert property (@(posedge clk) disable iff (!rstSync)
    (ce && state_r == ST_DUMMY && !dlpEnable) |=> ioOe == 4'h0)
    else $error("lines driven in dummy cycles");

  a_preamble_drive: assert property (@(posedge clk) disable iff (!rstSync)
    (ce && !csnF_r && state_r == ST_DUMMY && dlpEnable && isPre)
    |=> ioOe == 4'hF && ioOut == {4{$past(preBit)}})
    else $error("preamble not driven");

  a_data_drive: assert property (@(posedge clk) disable iff (!rstSync)
    (ce && !csnF_r && state_r == ST_DATA) |=> ioOe == 4'hF)
    else $error("data lines not driven");

endmodule : ddr_quad_read

// ---- core/ddr_quad_pkg.sv ----
// Constants and types shared by the four-line double-data-rate read block
package ddr_quad_pkg;

  // Instruction codes
  localparam logic [7:0] CMD_READ_DDR = 8'hED;
  localparam logic [7:0] CMD_READ_DDR4 = 8'hEE;
  localparam logic [7:0] CMD_MODE_RESET = 8'hFF;

  // Edge counts of the fixed-length phases; the instruction counts are rising edges only
  localparam logic [5:0] SPI_CMD_EDGES = 6'h08;
  localparam logic [5:0] QPI_CMD_EDGES = 6'h02;
  localparam logic [5:0] ADDR3_EDGES = 6'h06;
  localparam logic [5:0] ADDR4_EDGES = 6'h08;
  localparam logic [5:0] MODE_EDGES = 6'h02;
  localparam logic [6:0] PREAMBLE_EDGES = 7'h08;

  // Sizes, parameter defaults and an example preamble pattern
  localparam int MEM_ADDR_W_DEF = 10;
  localparam int FIFO_DEPTH_DEF = 16;
  localparam int BYTE_W = 8;
  localparam logic [7:0] DLP_EXAMPLE = 8'h34;

  // Serial clock limit the host keeps to, in MHz
  localparam int SCK_MAX_MHZ = 100;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_MODE,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } state_t;

endpackage : ddr_quad_pkg

// ---- core/byte_array.sv ----
// Flash array storage with a load port and a registered read port
module byte_array #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  input wire logic rdEn,
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData
);

  logic [DW-1:0] cells [0:(1<<AW)-1];

  ////////////////////////////////////////////////////////////////////////////////
  // Load port, used to preset contents
  always_ff @(posedge clk)
  begin
    if (ce && wrEn)
    begin
      cells[wrAddr] <= wrData;
    end
  end

  // Read data leave through a register
  always_ff @(posedge clk)
  begin
    if (ce && rdEn)
    begin
      rdData <= cells[rdAddr];
    end
  end

endmodule : byte_array

// ---- core/byte_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides and a flush
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);

  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(D);

  logic [W-1:0] slots [0:D-1];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Full and empty come straight from the count
  assign inReady = (count_r != FULL_CNT);
  assign outValid = (count_r != '0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = slots[rdPtr_r];

  ////////////////////////////////////////////////////////////////////////////////
  // Storage
  always_ff @(posedge clk)
  begin
    if (ce && push && !flush)
    begin
      slots[wrPtr_r] <= inData;
    end
  end

  // Pointers and count; flush drops everything at once
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else if (ce)
    begin
      if (flush)
      begin
        wrPtr_r <= '0;
        rdPtr_r <= '0;
        count_r <= '0;
      end
      else
      begin
        if (push)
        begin
          wrPtr_r <= (wrPtr_r == AW'(D - 1)) ? '0 : wrPtr_r + 1'b1;
        end
        if (pop)
        begin
          rdPtr_r <= (rdPtr_r == AW'(D - 1)) ? '0 : rdPtr_r + 1'b1;
        end
        count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end

endmodule : byte_fifo

// ---- test/flash_host_model.sv ----
// Host controller model that drives the serial clock, select and data lines
module flash_host_model (
  input wire logic clk,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOe,
  output logic sckPin,
  output logic csnPin,
  output logic [3:0] ioIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] hostOut = 4'h0;
  logic hostOe = 1'b0;
  logic flip = 1'b0;
  logic [3:0] rdS [0:127];
  logic [3:0] oeS [0:127];
  int nEdge = 0;
  int modeFall = 0;

  initial
  begin
    sckPin = 1'b0;
    csnPin = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // A released line must not hold its last level, so it toggles every clock;
  // it moves on the falling edge like every other input of the device
  always @(negedge clk)
    flip <= ~flip;

  // Device drive wins, then host drive, else the changing pattern
  always_comb
    for (int i = 0; i < 4; i++)
      ioIn[i] = ioOe[i] ? ioOut[i] : (hostOe ? hostOut[i] : flip);

  ////////////////////////////////////////////////////////////////////////////////
  // One clock edge: set lines, capture the line state, then toggle
  // Period 800 ns, far below the link limit; capture point is fixed per read
  task automatic sck_edge(input logic [3:0] d, input logic drive);
    hostOut = d;
    hostOe = drive;
    #200;
    rdS[nEdge] = ioIn;
    oeS[nEdge] = ioOe;
    nEdge++;
    sckPin = ~sckPin;
    #200;
  endtask : sck_edge

  // Whole read frame; select stays low through mode and dummy edges
  task automatic frame(input logic withInstr, input logic quadInstr, input logic [7:0] cmd,
                       input int addrNib, input logic [31:0] addr, input logic [7:0] mode,
                       input int lat, input int nData);
    nEdge = 0;
    csnPin = 1'b0;
    #400;
    if (withInstr && quadInstr)
      for (int k = 1; k >= 0; k--)
      begin
        sck_edge(cmd[k*4+:4], 1'b1);
        sck_edge(cmd[k*4+:4], 1'b1);
      end
    else if (withInstr)
      for (int k = 7; k >= 0; k--)
      begin
        sck_edge({3'h0, cmd[k]}, 1'b1);
        sck_edge({3'h0, cmd[k]}, 1'b1);
      end
    for (int k = addrNib - 1; k >= 0; k--)
      sck_edge(addr[k*4+:4], 1'b1);
    sck_edge(mode[7:4], 1'b1);
    modeFall = nEdge;
    sck_edge(mode[3:0], 1'b1);
    // Lines left floating from the first dummy edge on
    for (int k = 0; k < 2 * lat + 2 * nData + 2; k++)
      sck_edge(4'h0, 1'b0);
    csnPin = 1'b1;
    #800;
  endtask : frame

  // Two address edges, then select high before the mode bits
  task automatic short_frame(input logic [3:0] d);
    nEdge = 0;
    csnPin = 1'b0;
    #400;
    sck_edge(d, 1'b1);
    sck_edge(d, 1'b1);
    hostOe = 1'b0;
    csnPin = 1'b1;
    #800;
  endtask : short_frame
endmodule : flash_host_model

// ---- test/ddr_quad_read_tb.sv ----
// Self-checking bench for the four-line double-data-rate read block
module ddr_quad_read_tb import ddr_quad_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic sckPin, csnPin, contModeOut, busyOut;
  logic [3:0] ioIn, ioOut, ioOe;
  logic quadEnable = 1'b0;
  logic addrWidth = 1'b0;
  logic fourLineInstr = 1'b0;
  logic [3:0] readLatency = 4'h0;
  logic dlpEnable = 1'b0;
  logic [7:0] dlpPattern = DLP_EXAMPLE;
  logic loadEn = 1'b0;
  logic [9:0] loadAddr = 10'h000;
  logic [7:0] loadData = 8'h00;
  int bad_count = 0;
  int n_checks = 0;

  always #50 clk = ~clk;

  ddr_quad_read ddr_quad_read_inst (.clk(clk), .rstn(rstn), .ce(ce), .sckPin(sckPin),
    .csnPin(csnPin), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .quadEnable(quadEnable),
    .addrWidth(addrWidth), .fourLineInstr(fourLineInstr), .readLatency(readLatency),
    .dlpEnable(dlpEnable), .dlpPattern(dlpPattern), .loadEn(loadEn), .loadAddr(loadAddr),
    .loadData(loadData), .contModeOut(contModeOut), .busyOut(busyOut));

  flash_host_model host_inst (.clk(clk), .ioOut(ioOut), .ioOe(ioOe), .sckPin(sckPin),
    .csnPin(csnPin), .ioIn(ioIn));

  ////////////////////////////////////////////////////////////////////////////////
  // Array contents differ between the two wrap halves on purpose
  function automatic logic [7:0] mem_byte(input int a);
    return a[7:0] ^ {a[9:8], 6'h15};
  endfunction : mem_byte

  task automatic check_nib(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_nib

  task automatic check_flag(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : check_flag

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // Configuration changes land on the falling clock edge
  task automatic cfg(input logic qe, input logic aw, input logic fl, input logic [3:0] lat,
                     input logic learning_preamble);
    @(negedge clk);
    quadEnable = qe;
    addrWidth = aw;
    fourLineInstr = fl;
    readLatency = lat;
    dlpEnable = learning_preamble;
  endtask : cfg

  // Slot opened at edge j is captured before edge j+2
  task automatic check_data(input int startAddr, input int nData, input int lat);
    int base;
    logic [7:0] e;
    base = host_inst.modeFall + 2 * lat + 2;
    for (int n = 0; n < nData; n++)
    begin
      e = mem_byte((startAddr + n) % 1024);
      check_nib("data high", e[7:4], host_inst.rdS[base+2*n]);
      check_nib("data low", e[3:0], host_inst.rdS[base+2*n+1]);
    end
  endtask : check_data

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: a hang counts as a mismatch
  initial
  begin
    for (int i = 0; i < 90000; i++)
      @(posedge clk);
    bad_count++;
    results();
  end

  // Main sequence
  initial
  begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    for (int a = 0; a < 1024; a++)
    begin
      @(negedge clk);
      loadEn = 1'b1;
      loadAddr = a[9:0];
      loadData = mem_byte(a);
    end
    @(negedge clk);
    loadEn = 1'b0;
    cfg(1'b1, 1'b0, 1'b0, 4'h4, 1'b1);
    // Busy must rise inside the instruction phase and fall once select is high
    fork
      host_inst.frame(1'b1, 1'b0, CMD_READ_DDR, 6, 32'h0000_0010, 8'h00, 4, 3);
      begin
        repeat (40) @(negedge clk);
        check_flag("busy in frame", 1'b1, busyOut);
      end
    join
    check_flag("busy after frame", 1'b0, busyOut);
    for (int k = 0; k < 8; k++)
    begin
      check_nib("preamble", {4{DLP_EXAMPLE[7-k]}},
                host_inst.rdS[host_inst.modeFall+k+2]);
      check_nib("preamble drive", 4'hF, host_inst.oeS[host_inst.modeFall+k+2]);
    end
    check_data(16, 3, 4);
    check_flag("continuous", 1'b0, contModeOut);
    cfg(1'b1, 1'b1, 1'b0, 4'h2, 1'b0);
    host_inst.frame(1'b1, 1'b0, CMD_READ_DDR, 8, 32'h0000_03FE, 8'h5A, 2, 4);
    for (int k = 0; k < 4; k++)
      check_nib("dummy drive", 4'h0, host_inst.oeS[host_inst.modeFall+k+2]);
    check_data(1022, 4, 2);
    check_flag("continuous", 1'b1, contModeOut);
    cfg(1'b1, 1'b0, 1'b0, 4'h0, 1'b0);
    host_inst.frame(1'b0, 1'b0, 8'h00, 8, 32'h0000_0100, 8'hFF, 0, 2);
    check_data(256, 2, 0);
    check_flag("continuous", 1'b0, contModeOut);
    // Short latency keeps only the last two preamble bits of a new pattern
    cfg(1'b1, 1'b0, 1'b1, 4'h1, 1'b1);
    dlpPattern = 8'hC9;
    host_inst.frame(1'b1, 1'b1, CMD_READ_DDR4, 8, 32'h0000_0020, 8'hA5, 1, 2);
    for (int k = 0; k < 2; k++)
      check_nib("short preamble", {4{dlpPattern[1-k]}},
                host_inst.rdS[host_inst.modeFall+k+2]);
    check_data(32, 2, 1);
    check_flag("continuous", 1'b1, contModeOut);
    host_inst.short_frame(CMD_MODE_RESET[7:4]);
    check_flag("continuous", 1'b0, contModeOut);
    cfg(1'b0, 1'b0, 1'b0, 4'h2, 1'b1);
    host_inst.frame(1'b1, 1'b0, CMD_READ_DDR, 6, 32'h0000_0040, 8'h00, 2, 2);
    for (int m = 0; m < host_inst.nEdge; m++)
      check_nib("refused drive", 4'h0, host_inst.oeS[m]);
    results();
  end
endmodule : ddr_quad_read_tb
